// ==== pkg/status_pin_pkg.sv ====
// constants for the second status indicator pin source selector
// assumes an avalon-mm slave with 32-bit data and byte addresses
`default_nettype none

package status_pin_pkg;

  // ****************************************************************
  // register map (byte addresses, one aligned word each)
  // ****************************************************************
  localparam logic [7:0] STATUS_PIN1_CONFIG_OFFSET = 8'h1c;
  localparam logic [7:0] DIAG_CONFIG_OFFSET        = 8'h20;
  localparam logic [7:0] PIN_STATE_OFFSET          = 8'h24;
  localparam int         ADDR_W                    = 8;
  localparam int         DATA_W                    = 32;

  // ****************************************************************
  // field layout and reset values
  // ****************************************************************
  localparam int         SOURCE_SELECT_MSB     = 7;
  localparam int         SOURCE_SELECT_LSB     = 4;
  localparam int         POLARITY_BIT          = 3;
  localparam logic [3:0] SOURCE_SELECT_RESET   = 4'h2;
  localparam logic       POLARITY_RESET        = 1'b1;
  localparam int         DIAG_ENABLE_BIT       = 0;
  localparam int         DIAG_LEVEL_BIT        = 1;
  localparam int         STATE_PIN_BIT         = 0;
  localparam int         STATE_RAW_BIT         = 1;
  localparam int         STATE_CODE_LSB        = 4;
  localparam int         FLAG_COUNT            = 8;

  // divider taps handed to the half-rate stage
  localparam int         TAP_COUNT   = 6;
  localparam int         TAP_R_A     = 0;
  localparam int         TAP_R_B     = 1;
  localparam int         TAP_N_A     = 2;
  localparam int         TAP_N_B     = 3;
  localparam int         TAP_M_A     = 4;
  localparam int         TAP_M_B     = 5;

  // ****************************************************************
  // source select codes
  // ****************************************************************
  typedef enum logic [3:0] {
    SRC_PRI_LOSS    = 4'h0,
    SRC_SEC_LOSS    = 4'h1,
    SRC_A_LOCK_LOSS = 4'h2,
    SRC_A_R_HALF    = 4'h3,
    SRC_A_N_HALF    = 4'h4,
    SRC_B_LOCK_LOSS = 4'h5,
    SRC_B_R_HALF    = 4'h6,
    SRC_B_N_HALF    = 4'h7,
    SRC_A_VCO_CAL   = 4'h8,
    SRC_B_VCO_CAL   = 4'h9,
    SRC_INTERRUPT   = 4'ha,
    SRC_A_M_HALF    = 4'hb,
    SRC_B_M_HALF    = 4'hc,
    SRC_EEPROM_BUSY = 4'hd,
    SRC_A_SWITCH    = 4'he,
    SRC_B_SWITCH    = 4'hf
  } source_code_type;

endpackage

`default_nettype wire

// ==== hw/half_rate_divider.sv ====
// divide-by-two stage for one internal divider output
// assumes the divider output is synchronous to ref_clk_i
`default_nettype none

module half_rate_divider
  import status_pin_pkg::*;
(
  input  wire logic ref_clk_i,
  input  wire logic rstn_i,
  input  wire logic div_i,
  input  wire logic bypass_i,
  output var  logic half_o
);

  logic div_prev_reg;
  logic half_reg;
  logic rise;

  // toggle on each rising edge of the divider output
  assign rise   = div_i & ~div_prev_reg;
  assign half_o = half_reg;

  // bypassed divider gives no usable tap, so hold low
  always_ff @(posedge ref_clk_i)
  begin
    if (!rstn_i)
    begin
      div_prev_reg <= 1'b0;
      half_reg     <= 1'b0;
    end
    else
    begin
      div_prev_reg <= div_i;
      if (bypass_i)
        half_reg <= 1'b0;
      else if (rise)
        half_reg <= ~half_reg;
    end
  end

endmodule

`default_nettype wire

// ==== hw/status_pin_source_mux.sv ====
// second status indicator pin: source selection, polarity, diagnostic override
// assumes all condition inputs are synchronous to ref_clk_i (25 mhz)
// Behaviour
// - a 4-bit source select in bits 7:4 of the config register, reset 0x2, picks the pin source.
// - codes 0 and 1 show signal loss on the primary and secondary reference inputs.
// - code 2 shows lock loss of synth_a and code 5 lock loss of synth_b.
// - codes 3 and 6 show the R divider of synth_a and synth_b halved, valid when not bypassed.
// - codes 4 and 7 show the N divider of synth_a and synth_b halved.
// - codes 11 and 12 show the M divider of synth_a and synth_b halved, valid when not bypassed.
// - codes 8 and 9 assert the pin while synth_a or synth_b vco calibration runs.
// - code 10 shows the interrupt indication, derived from the interrupt flag bits.
// - codes 14 and 15 show a secondary-to-primary switch-back of synth_a or synth_b.
// - polarity bit 3, reset 1, makes the pin active high when 1 and active low when 0.
// - an active diagnostic setting overrides both source select and polarity.
//
// Implementation choice: the Avalon-MM slave port.
`default_nettype none

module status_pin_source_mux
  import status_pin_pkg::*;
#(
  parameter int FLAGS = FLAG_COUNT
)
(
  input  wire logic                 ref_clk_i,
  input  wire logic                 rstn_i,
  // avalon-mm slave
  input  wire logic [ADDR_W-1:0]    address_i,
  input  wire logic                 read_i,
  input  wire logic                 write_i,
  input  wire logic [DATA_W-1:0]    writedata_i,
  input  wire logic [3:0]           byteenable_i,
  output var  logic [DATA_W-1:0]    readdata_o,
  output logic                      waitrequest_o,
  // internal conditions
  input  wire logic                 primary_signal_loss_i,
  input  wire logic                 secondary_signal_loss_i,
  input  wire logic                 synth_a_lock_loss_i,
  input  wire logic                 synth_b_lock_loss_i,
  input  wire logic                 synth_a_r_div_i,
  input  wire logic                 synth_b_r_div_i,
  input  wire logic                 synth_a_n_div_i,
  input  wire logic                 synth_b_n_div_i,
  input  wire logic                 synth_a_m_div_i,
  input  wire logic                 synth_b_m_div_i,
  input  wire logic                 synth_a_r_bypass_i,
  input  wire logic                 synth_b_r_bypass_i,
  input  wire logic                 synth_a_m_bypass_i,
  input  wire logic                 synth_b_m_bypass_i,
  input  wire logic                 synth_a_vco_cal_i,
  input  wire logic                 synth_b_vco_cal_i,
  input  wire logic [FLAGS-1:0]     interrupt_flag_bits_i,
  input  wire logic                 eeprom_busy_i,
  input  wire logic                 synth_a_switch_back_i,
  input  wire logic                 synth_b_switch_back_i,
  // pin
  output var  logic                 status_pin1_o
);

  // ****************************************************************
  // register state
  // ****************************************************************
  source_code_type      status_pin1_source_select_reg;
  logic                 status_pin1_polarity_reg;
  logic                 diag_enable_reg;
  logic                 diag_level_reg;
  logic                 ack_reg;
  logic [DATA_W-1:0]    readdata_reg;
  logic                 status_pin1_reg;
  logic                 raw_reg;

  // ****************************************************************
  // bus decode
  // ****************************************************************
  logic                 request;
  logic                 accept;
  logic                 hit_config;
  logic                 hit_diag;
  logic                 hit_state;
  logic                 write_config;
  logic                 write_diag;
  logic [DATA_W-1:0]    config_word;
  logic [DATA_W-1:0]    diag_word;
  logic [DATA_W-1:0]    state_word;
  logic [DATA_W-1:0]    readdata_next;

  // one wait cycle per access keeps the read mux off the critical path
  assign request       = read_i | write_i;
  assign accept        = request & ~ack_reg;
  assign waitrequest_o = request & ~ack_reg;

  assign hit_config    = (address_i == STATUS_PIN1_CONFIG_OFFSET);
  assign hit_diag      = (address_i == DIAG_CONFIG_OFFSET);
  assign hit_state     = (address_i == PIN_STATE_OFFSET);

  // only lane 0 carries fields; other lanes are ignored
  assign write_config  = accept & write_i & hit_config & byteenable_i[0];
  assign write_diag    = accept & write_i & hit_diag & byteenable_i[0];

  // ****************************************************************
  // read words, reserved bits read zero
  // ****************************************************************
  function automatic logic [DATA_W-1:0] place_bit(input logic value, input int pos);
    logic [DATA_W-1:0] word;
    word      = '0;
    word[pos] = value;
    return word;
  endfunction

  assign config_word =
    (DATA_W'(status_pin1_source_select_reg) << SOURCE_SELECT_LSB)
    | place_bit(status_pin1_polarity_reg, POLARITY_BIT);
  assign diag_word   = place_bit(diag_enable_reg, DIAG_ENABLE_BIT)
                     | place_bit(diag_level_reg, DIAG_LEVEL_BIT);
  assign state_word  = place_bit(status_pin1_reg, STATE_PIN_BIT)
                     | place_bit(raw_reg, STATE_RAW_BIT)
                     | (DATA_W'(status_pin1_source_select_reg) << STATE_CODE_LSB);

  // unmapped addresses read zero and swallow writes
  assign readdata_next = hit_config ? config_word :
                         hit_diag   ? diag_word   :
                         hit_state  ? state_word  : '0;

  assign readdata_o    = readdata_reg;

  // ****************************************************************
  // bus handshake
  // ****************************************************************
  // ack pulses for one cycle, so a held request is served again every second cycle
  always_ff @(posedge ref_clk_i)
  begin
    if (!rstn_i)
    begin
      ack_reg      <= 1'b0;
      readdata_reg <= '0;
    end
    else
    begin
      ack_reg <= accept;
      if (accept & read_i)
        readdata_reg <= readdata_next;
    end
  end

  // ****************************************************************
  // configuration registers
  // ****************************************************************
  // reset values give lock loss of synth_a, active high
  always_ff @(posedge ref_clk_i)
  begin
    if (!rstn_i)
    begin
      status_pin1_source_select_reg <= source_code_type'(SOURCE_SELECT_RESET);
      status_pin1_polarity_reg      <= POLARITY_RESET;
    end
    else if (write_config)
    begin
      status_pin1_source_select_reg <=
        source_code_type'(writedata_i[SOURCE_SELECT_MSB:SOURCE_SELECT_LSB]);
      status_pin1_polarity_reg      <= writedata_i[POLARITY_BIT];
    end
  end

  // diagnostic override starts off
  always_ff @(posedge ref_clk_i)
  begin
    if (!rstn_i)
    begin
      diag_enable_reg <= 1'b0;
      diag_level_reg  <= 1'b0;
    end
    else if (write_diag)
    begin
      diag_enable_reg <= writedata_i[DIAG_ENABLE_BIT];
      diag_level_reg  <= writedata_i[DIAG_LEVEL_BIT];
    end
  end

  // ****************************************************************
  // halved divider taps
  // ****************************************************************
  logic [TAP_COUNT-1:0] tap_div;
  logic [TAP_COUNT-1:0] tap_bypass;
  logic [TAP_COUNT-1:0] tap_half;

  assign tap_div[TAP_R_A]    = synth_a_r_div_i;
  assign tap_div[TAP_R_B]    = synth_b_r_div_i;
  assign tap_div[TAP_N_A]    = synth_a_n_div_i;
  assign tap_div[TAP_N_B]    = synth_b_n_div_i;
  assign tap_div[TAP_M_A]    = synth_a_m_div_i;
  assign tap_div[TAP_M_B]    = synth_b_m_div_i;

  // n dividers have no bypass; r and m taps go quiet when bypassed
  assign tap_bypass[TAP_R_A] = synth_a_r_bypass_i;
  assign tap_bypass[TAP_R_B] = synth_b_r_bypass_i;
  assign tap_bypass[TAP_N_A] = 1'b0;
  assign tap_bypass[TAP_N_B] = 1'b0;
  assign tap_bypass[TAP_M_A] = synth_a_m_bypass_i;
  assign tap_bypass[TAP_M_B] = synth_b_m_bypass_i;

  // each tap toggles on rising edges of its divider output
  for (genvar t = 0; t < TAP_COUNT; t++)
  begin : g_half
    half_rate_divider u_half
    (
      .ref_clk_i (ref_clk_i),
      .rstn_i    (rstn_i),
      .div_i     (tap_div[t]),
      .bypass_i  (tap_bypass[t]),
      .half_o    (tap_half[t])
    );
  end

  // ****************************************************************
  // source selection
  // ****************************************************************
  logic interrupt_indication;
  logic raw_level;
  logic pin_next;

  // any pending flag raises the interrupt indication
  assign interrupt_indication = |interrupt_flag_bits_i;

  // all sixteen codes are legal, so no default branch
  always_comb
  begin
    raw_level = 1'b0;
    unique case (status_pin1_source_select_reg)
      SRC_PRI_LOSS:    raw_level = primary_signal_loss_i;
      SRC_SEC_LOSS:    raw_level = secondary_signal_loss_i;
      SRC_A_LOCK_LOSS: raw_level = synth_a_lock_loss_i;
      SRC_B_LOCK_LOSS: raw_level = synth_b_lock_loss_i;
      SRC_A_R_HALF:    raw_level = tap_half[TAP_R_A];
      SRC_B_R_HALF:    raw_level = tap_half[TAP_R_B];
      SRC_A_N_HALF:    raw_level = tap_half[TAP_N_A];
      SRC_B_N_HALF:    raw_level = tap_half[TAP_N_B];
      SRC_A_M_HALF:    raw_level = tap_half[TAP_M_A];
      SRC_B_M_HALF:    raw_level = tap_half[TAP_M_B];
      SRC_A_VCO_CAL:   raw_level = synth_a_vco_cal_i;
      SRC_B_VCO_CAL:   raw_level = synth_b_vco_cal_i;
      SRC_INTERRUPT:   raw_level = interrupt_indication;
      SRC_EEPROM_BUSY: raw_level = eeprom_busy_i;
      SRC_A_SWITCH:    raw_level = synth_a_switch_back_i;
      SRC_B_SWITCH:    raw_level = synth_b_switch_back_i;
    endcase
  end

  // diagnostic level wins over selection and polarity alike
  assign pin_next = diag_enable_reg ? diag_level_reg
                  : (status_pin1_polarity_reg ? raw_level : ~raw_level);

  // ****************************************************************
  // pin register
  // ****************************************************************
  // registered pin avoids glitches when the select changes
  always_ff @(posedge ref_clk_i)
  begin
    if (!rstn_i)
    begin
      status_pin1_reg <= 1'b0;
      raw_reg         <= 1'b0;
    end
    else
    begin
      status_pin1_reg <= pin_next;
      raw_reg         <= raw_level;
    end
  end

  assign status_pin1_o = status_pin1_reg;

endmodule

`default_nettype wire

// ==== test/pin_monitor_model.sv ====
// board-side watcher of the status pin: counts level changes
// assumes the pin is sampled on the same 25 mhz clock as the design
`default_nettype none

module pin_monitor_model
(
  input  wire logic        ref_clk_i,
  input  wire logic        rstn_i,
  input  wire logic        pin_i,
  output var  logic [15:0] edge_count_o
);
  logic last_reg;

  // a toggle count lets the bench judge half-rate taps without phase guesses
  always_ff @(posedge ref_clk_i)
  begin
    last_reg <= pin_i;
    if (!rstn_i)
      edge_count_o <= 16'h0;
    else if (pin_i != last_reg)
      edge_count_o <= edge_count_o + 16'h1;
  end
endmodule

`default_nettype wire

// ==== test/status_pin_properties.sv ====
// concurrent checks on the status pin selector ports
// assumes binding to status_pin_source_mux; config is mirrored from bus writes
`default_nettype none

module status_pin_props
  import status_pin_pkg::*;
#(
  parameter int FLAGS = FLAG_COUNT
)
(
  input wire logic              ref_clk_i, rstn_i, read_i, write_i, waitrequest_o,
  input wire logic [ADDR_W-1:0] address_i,
  input wire logic [DATA_W-1:0] writedata_i, readdata_o,
  input wire logic [3:0]        byteenable_i,
  input wire logic              status_pin1_o, primary_signal_loss_i, secondary_signal_loss_i,
  input wire logic              synth_a_lock_loss_i, synth_b_lock_loss_i, eeprom_busy_i,
  input wire logic              synth_a_r_div_i, synth_b_r_div_i, synth_a_n_div_i,
  input wire logic              synth_b_n_div_i, synth_a_m_div_i, synth_b_m_div_i,
  input wire logic              synth_a_r_bypass_i, synth_b_r_bypass_i,
  input wire logic              synth_a_m_bypass_i, synth_b_m_bypass_i,
  input wire logic              synth_a_vco_cal_i, synth_b_vco_cal_i,
  input wire logic [FLAGS-1:0]  interrupt_flag_bits_i,
  input wire logic              synth_a_switch_back_i, synth_b_switch_back_i
);
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (!rstn_i);

  // ****************************************************************
  // mirror of the configuration, updated when the write is accepted
  // ****************************************************************
  logic [3:0] sel_reg;
  logic       pol_reg, diag_en_reg, diag_lvl_reg;
  logic [1:0] settle_reg;
  wire        cfg_wr  = write_i && waitrequest_o && byteenable_i[0];
  wire        settled = (settle_reg == 2'h3);
  always_ff @(posedge ref_clk_i)
  begin
    if (!rstn_i)
    begin
      sel_reg      <= 4'h2;
      pol_reg      <= 1'b1;
      diag_en_reg  <= 1'b0;
      diag_lvl_reg <= 1'b0;
      settle_reg   <= 2'h0;
    end
    else
    begin
      settle_reg <= settled ? settle_reg : settle_reg + 2'h1;
      if (cfg_wr && address_i == STATUS_PIN1_CONFIG_OFFSET)
        {sel_reg, pol_reg} <= writedata_i[7:3];
      if (cfg_wr && address_i == DIAG_CONFIG_OFFSET)
        {diag_lvl_reg, diag_en_reg} <= writedata_i[1:0];
    end
  end

  // selected condition, level codes only; taps handled apart
  wire [15:0] src_vec  = {synth_b_switch_back_i, synth_a_switch_back_i, eeprom_busy_i, 2'b00,
                          |interrupt_flag_bits_i, synth_b_vco_cal_i, synth_a_vco_cal_i, 2'b00,
                          synth_b_lock_loss_i, 2'b00, synth_a_lock_loss_i,
                          secondary_signal_loss_i, primary_signal_loss_i};
  wire [15:0] byp_vec  = {3'b000, synth_b_m_bypass_i, synth_a_m_bypass_i, 4'h0,
                          synth_b_r_bypass_i, 2'b00, synth_a_r_bypass_i, 3'b000};
  wire        cond     = src_vec[sel_reg];
  wire        lvl_case = settled && !diag_en_reg && 16'he727 >> sel_reg & 16'h1;
  wire        byp_case = settled && !diag_en_reg && byp_vec[sel_reg];
  wire        n_sel    = settled && !diag_en_reg && (sel_reg == 4'h4 || sel_reg == 4'h7);
  wire        n_tap    = sel_reg[0] ? synth_b_n_div_i : synth_a_n_div_i;
  wire        mapped   = address_i inside {STATUS_PIN1_CONFIG_OFFSET, DIAG_CONFIG_OFFSET,
                                           PIN_STATE_OFFSET};

  // ****************************************************************
  // bus handshake and readback
  // ****************************************************************
  AST_WAIT_FIRST: assert property ((read_i || write_i) && !$past(read_i || write_i)
    |-> waitrequest_o) else $error("no wait in first request cycle");
  AST_WAIT_ONE: assert property ((read_i || write_i) && waitrequest_o |=> !waitrequest_o)
    else $error("wait longer than one cycle");
  AST_IDLE_NOWAIT: assert property (!(read_i || write_i) |-> !waitrequest_o)
    else $error("wait raised while idle");
  AST_CFG_READ: assert property (read_i && !waitrequest_o && address_i == 8'h1c
    |-> readdata_o == {24'h0, sel_reg, pol_reg, 3'h0}) else $error("config readback wrong");
  AST_UNMAPPED_READ: assert property (read_i && !waitrequest_o && !mapped
    |-> readdata_o == '0) else $error("unmapped read not zero");

  // ****************************************************************
  // pin behaviour
  // ****************************************************************
  AST_LEVEL_SRC: assert property ($past(lvl_case && pol_reg)
    |-> status_pin1_o == $past(cond)) else $error("pin not the selected condition");
  AST_POLARITY_LOW: assert property ($past(lvl_case && !pol_reg)
    |-> status_pin1_o == !$past(cond)) else $error("active low pin wrong");
  AST_DIAG_OVERRIDE: assert property ($past(settled && diag_en_reg)
    |-> status_pin1_o == $past(diag_lvl_reg)) else $error("diagnostic level not on pin");
  AST_BYPASS_IDLE: assert property ((byp_case && $stable(pol_reg))[*3]
    |-> status_pin1_o == !pol_reg) else $error("bypassed tap not inactive");
  AST_N_TOGGLE: assert property (n_sel && $stable(sel_reg) && $rose(n_tap)
    ##1 n_sel && $stable({sel_reg, pol_reg}) ##1 1'b1
    |-> status_pin1_o != $past(status_pin1_o)) else $error("halved tap did not toggle");

  // main scenarios reached
  CV_TAP: cover property (n_sel && $rose(n_tap));
  CV_DIAG: cover property (settled && diag_en_reg && diag_lvl_reg);
  CV_BYPASS: cover property (byp_case);
  CV_LOW: cover property (lvl_case && !pol_reg && cond);
endmodule

bind status_pin_source_mux status_pin_props #(.FLAGS(FLAGS)) u_status_pin_props (.*);

`default_nettype wire

// ==== test/test_status_pin_source_mux.sv ====
// self-checking bench for the status pin source selector
// assumes the checker is bound in and the pin monitor model sits on the pin
`default_nettype none

module test_status_pin_source_mux;
  import status_pin_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;

  logic        ref_clk_i = 1'b0;
  logic        rstn_i    = 1'b0;
  logic [7:0]  address   = 8'h0;
  logic        read      = 1'b0;
  logic        write     = 1'b0;
  logic [31:0] wdata     = 32'h0;
  logic [3:0]  be        = 4'h0;
  logic [8:0]  lv        = 9'h0;
  logic [7:0]  flg       = 8'h0;
  logic [3:0]  byp       = 4'h0;
  logic [5:0]  dv        = 6'h0;
  logic [31:0] seed      = 32'h17a49;
  logic [31:0] rdata_q;
  logic [31:0] exp_w;
  logic [15:0] e0;
  logic [3:0]  tap_code [6] = '{4'h3, 4'h6, 4'h4, 4'h7, 4'hb, 4'hc};
  wire  [31:0] readdata;
  wire         waitreq, pin;
  wire  [15:0] edges;
  wire  [31:0] pin_w = {31'h0, pin};
  int          fail_count = 0;
  int          tests_run  = 0;

  always #20 ref_clk_i = ~ref_clk_i;

  status_pin_source_mux u_status_pin_source_mux (
    .ref_clk_i(ref_clk_i), .rstn_i(rstn_i), .address_i(address), .read_i(read),
    .write_i(write), .writedata_i(wdata), .byteenable_i(be), .readdata_o(readdata),
    .waitrequest_o(waitreq), .primary_signal_loss_i(lv[0]), .secondary_signal_loss_i(lv[1]),
    .synth_a_lock_loss_i(lv[2]), .synth_b_lock_loss_i(lv[3]), .synth_a_vco_cal_i(lv[4]),
    .synth_b_vco_cal_i(lv[5]), .eeprom_busy_i(lv[6]), .synth_a_switch_back_i(lv[7]),
    .synth_b_switch_back_i(lv[8]), .interrupt_flag_bits_i(flg),
    .synth_a_r_div_i(dv[TAP_R_A]), .synth_b_r_div_i(dv[TAP_R_B]),
    .synth_a_n_div_i(dv[TAP_N_A]), .synth_b_n_div_i(dv[TAP_N_B]),
    .synth_a_m_div_i(dv[TAP_M_A]), .synth_b_m_div_i(dv[TAP_M_B]),
    .synth_a_r_bypass_i(byp[0]), .synth_b_r_bypass_i(byp[1]),
    .synth_a_m_bypass_i(byp[2]), .synth_b_m_bypass_i(byp[3]), .status_pin1_o(pin));

  pin_monitor_model u_pin_monitor_model (
    .ref_clk_i(ref_clk_i), .rstn_i(rstn_i), .pin_i(pin), .edge_count_o(edges));

  // ****************************************************************
  // helpers
  // ****************************************************************
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] t;
    t = s ^ (s << 13);
    t = t ^ (t >> 17);
    return t ^ (t << 5);
  endfunction

  // r and m taps read as inactive here because the bench bypasses them
  function automatic logic cond(input logic [3:0] c);
    logic [15:0] v;
    v = {lv[8:6], 2'b00, |flg, lv[5:4], 2'b00, lv[3], 2'b00, lv[2:0]};
    return v[c];
  endfunction

  task automatic summarize();
    $display("comparisons %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // one avalon transfer, judged only at rising edges; the design's registers move in the
  // nonblocking region, so right after the edge the settled pre-edge values are still seen
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
                     input logic [3:0] b);
    int n;
    @(posedge ref_clk_i);
    read    <= !w;
    write   <= w;
    address <= a;
    wdata   <= d;
    be      <= b;
    n = 0;
    do
    begin
      @(posedge ref_clk_i);
      n++;
    end
    while (waitreq !== 1'b0 && n < 20);
    rdata_q = readdata;
    read  <= 1'b0;
    write <= 1'b0;
    if (waitreq !== 1'b0)
    begin
      fail_count++;
      summarize();
    end
  endtask

  // covers the one or two cycle pin latency with margin
  task automatic settle();
    repeat (3) @(posedge ref_clk_i);
    @(negedge ref_clk_i);
  endtask

  // ****************************************************************
  // main sequence
  // ****************************************************************
  initial
  begin
    repeat (16) @(posedge ref_clk_i);
    rstn_i <= 1'b1;
    bus(1'b0, STATUS_PIN1_CONFIG_OFFSET, 32'h0, 4'hf);
    check("config reset", rdata_q, 32'h28);
    @(posedge ref_clk_i);
    lv <= 9'h004;
    settle();
    check("pin after reset", {31'h0, pin}, 32'h1);
    bus(1'b1, STATUS_PIN1_CONFIG_OFFSET, 32'hf0, 4'he);
    bus(1'b0, STATUS_PIN1_CONFIG_OFFSET, 32'h0, 4'hf);
    check("lane off write", rdata_q, 32'h28);
    bus(1'b1, 8'h40, 32'hff, 4'hf);
    bus(1'b0, 8'h40, 32'h0, 4'hf);
    check("unmapped read", rdata_q, 32'h0);
    $display("reset and refusal test done");
    for (int c = 0; c < 32; c++)
    begin
      seed = xs(seed);
      bus(1'b1, STATUS_PIN1_CONFIG_OFFSET, {24'h0, 4'(c), seed[20], 3'h0}, 4'h1);
      bus(1'b0, STATUS_PIN1_CONFIG_OFFSET, 32'h0, 4'hf);
      check("config readback", rdata_q, {24'h0, 4'(c), seed[20], 3'h0});
      @(posedge ref_clk_i);
      lv  <= seed[8:0];
      flg <= seed[31] ? 8'h1 << seed[27:25] : 8'h0;
      byp <= 4'hf;
      settle();
      exp_w = {31'h0, ~(cond(4'(c)) ^ seed[20])};
      if (4'(c) != 4'h4 && 4'(c) != 4'h7)
        check("level", pin_w, exp_w);
    end
    $display("source code test done");
    for (int t = 0; t < TAP_COUNT; t++)
    begin
      seed = xs(seed);
      bus(1'b1, STATUS_PIN1_CONFIG_OFFSET, {24'h0, tap_code[t], seed[3], 3'h0}, 4'h1);
      @(posedge ref_clk_i);
      byp <= 4'h0;
      settle();
      e0 = edges;
      repeat (5)
      begin
        @(posedge ref_clk_i);
        dv[t] <= 1'b1;
        @(posedge ref_clk_i);
        dv[t] <= 1'b0;
      end
      settle();
      check("tap toggles", 32'(edges - e0), 32'h5);
    end
    $display("divider tap test done");
    bus(1'b1, STATUS_PIN1_CONFIG_OFFSET, 32'h20, 4'h1);
    bus(1'b1, DIAG_CONFIG_OFFSET, 32'h3, 4'h1);
    settle();
    check("diag high", {31'h0, pin}, 32'h1);
    @(posedge ref_clk_i);
    lv <= 9'h0;
    bus(1'b1, DIAG_CONFIG_OFFSET, 32'h1, 4'h1);
    settle();
    check("diag low", {31'h0, pin}, 32'h0);
    bus(1'b0, PIN_STATE_OFFSET, 32'h0, 4'hf);
    check("pin state", rdata_q, 32'h20);
    bus(1'b0, DIAG_CONFIG_OFFSET, 32'h0, 4'hf);
    check("diag readback", rdata_q, 32'h1);
    bus(1'b1, DIAG_CONFIG_OFFSET, 32'h0, 4'h1);
    settle();
    check("diag off", {31'h0, pin}, 32'h1);
    $display("diagnostic test done");
    @(posedge ref_clk_i);
    rstn_i <= 1'b0;
    repeat (2) @(posedge ref_clk_i);
    rstn_i <= 1'b1;
    bus(1'b0, STATUS_PIN1_CONFIG_OFFSET, 32'h0, 4'hf);
    check("config second reset", rdata_q, 32'h28);
    $display("second reset test done");
    summarize();
  end
endmodule

`default_nettype wire
